// ### rtl/vosm_top.sv
// What this block does
// - Bypass on enable low or mode 11b
// - Both selects low loads mode 11b
// - Bypass routes around buffer, buffer sleeps
// - Bus data changes away from output clock rise; status pins change on any mclk
// - Select pins choose raw, video or transport
// - Select pins inputs manually, outputs automatically
// - Reset tri-states outputs, status pins hold
// - Video mode passes aligned multiplexed words
// - Transport byte on bits 7 to 0
// - Bit 9 code error, bit 8 sync
// - Data-through passes words untouched
// - Auto mode without sync forces zeros
// - Four status pins, 3-bit select each
// - Select codes map eight internal signals
// - Irrelevant status selection tri-states pin
// - Video defaults H, V, F, load
// - Transport defaults full, empty; else 000b
// - Aux mode waits 2200 clocks before extraction
//
// Purpose: Output stage formatting the 10-bit bus and the four status pins
// Assumes: Core signals arrive on mclk; pins are asynchronous
// Notes: Parallel clock is sampled by mclk and re-driven
`timescale 1ns/10ps
`default_nettype none
`include "vosm_defines.svh"

module vosm_top #(
   parameter int INIT_CYCLES = `VOSM_AUX_INIT_PCLK,
   parameter int DATA_W = 10,
   parameter int NSTAT = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pins from outside
   input wire logic pclk_in,
   input wire logic buffer_enable_pin,
   input wire logic processing_enable_pin,
   // Select pins, two-way
   input wire logic video_decode_select_in,
   output logic video_decode_select_out,
   output logic video_decode_select_oe,
   input wire logic transport_select_in,
   output logic transport_select_out,
   output logic transport_select_oe,
   // Core data and detection
   input wire logic [DATA_W-1:0] raw_word,
   input wire logic [DATA_W-1:0] video_word,
   input wire logic [7:0] ts_byte,
   input wire logic code_word_error,
   input wire logic sync_word_indication,
   input wire logic trs_found,
   input wire logic sync_found,
   input wire logic detect_video,
   input wire logic detect_ts,
   input wire logic error_summary_in,
   // Status sources
   input wire logic h_flag,
   input wire logic v_flag,
   input wire logic f_flag,
   input wire logic buffer_load_pulse,
   input wire logic aux_packet_flag,
   input wire logic error_check_packet_flag,
   input wire logic buffer_full,
   input wire logic buffer_empty,
   // Parallel outputs
   output logic [DATA_W-1:0] dout,
   output logic dout_oe,
   output logic pclk_out,
   output logic pclk_oe,
   output logic [NSTAT-1:0] stat_out,
   output logic [NSTAT-1:0] stat_oe,
   output logic error_summary_n,
   // Buffer control
   output logic buffer_bypass,
   output logic buffer_sleep,
   output logic aux_extract_enable,
   output logic half_swap_bit
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [4:0] pins_q;
   logic pclk_prev_reg;

   vosm_pin_sync #(.WIDTH(5)) u_sync (
      .clk(mclk),
      .resetn(resetn),
      .d({transport_select_in, video_decode_select_in, processing_enable_pin, buffer_enable_pin, pclk_in}),
      .q(pins_q)
   );

   wire logic pclk_s = pins_q[0];
   wire logic buf_en_s = pins_q[1];
   wire logic proc_en_s = pins_q[2];
   wire logic pclk_rise = pclk_s & ~pclk_prev_reg;
   wire logic pclk_fall = ~pclk_s & pclk_prev_reg;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         pclk_prev_reg <= 1'b0;
      else
         pclk_prev_reg <= pclk_s;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [1:0] buf_mode_reg;
   logic auto_reg;
   logic [NSTAT*3-1:0] sel_reg;
   logic [NSTAT-1:0] sel_written_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic bypass_reg;
   vosm_pkg::vosm_fmt_type fmt_reg;
   vosm_pkg::vosm_fmt_type fmt_prev_reg;
   logic [1:0] mode_prev_reg;
   vosm_pkg::vosm_init_type init_reg;
   logic [11:0] init_cnt_reg;

   wire logic addr_ok = hsel & hready & htrans[1];
   wire logic wr_ctrl = wr_pend_reg & (wr_addr_reg == `VOSM_CTRL_OFS);
   wire logic wr_sel = wr_pend_reg & (wr_addr_reg == `VOSM_SEL_OFS);
   wire logic cfg_change = (fmt_reg != fmt_prev_reg) | (buf_mode_reg != mode_prev_reg);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend_reg <= addr_ok & hwrite;
         wr_addr_reg <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data loaded at the address phase, zero when unmapped
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ok & ~hwrite)
      begin
         unique case (haddr[7:0])
            `VOSM_CTRL_OFS:
               hrdata <= {19'h0_0000, half_swap_bit, 9'h000, auto_reg, buf_mode_reg};
            `VOSM_SEL_OFS:
               hrdata <= {16'h0000, 1'b0, sel_reg[11:9], 1'b0, sel_reg[8:6], 1'b0, sel_reg[5:3], 1'b0, sel_reg[2:0]};
            `VOSM_STATUS_OFS:
               hrdata <= {26'h000_0000, transport_select_out, video_decode_select_out, fmt_reg, bypass_reg,
                          init_reg == vosm_pkg::VOSM_INIT_READY};
            default:
               hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Host write lands after any default load in the same cycle
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         buf_mode_reg <= `VOSM_MODE_RESET;
         auto_reg <= 1'b0;
         half_swap_bit <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         buf_mode_reg <= hwdata[`VOSM_CTRL_MODE_LSB +: 2];
         auto_reg <= hwdata[`VOSM_CTRL_AUTO_BIT];
         half_swap_bit <= hwdata[`VOSM_CTRL_SWAP_BIT];
      end
      else if (fmt_reg == vosm_pkg::VOSM_FMT_RAW && fmt_prev_reg != vosm_pkg::VOSM_FMT_RAW)
         buf_mode_reg <= `VOSM_MODE_BYPASS;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         fmt_prev_reg <= vosm_pkg::VOSM_FMT_RAW;
         mode_prev_reg <= `VOSM_MODE_RESET;
      end
      else
      begin
         fmt_prev_reg <= fmt_reg;
         mode_prev_reg <= buf_mode_reg;
      end
   end

   // ----------------------------------------
   // Format selection
   // ----------------------------------------
   // In auto mode the detectors drive the select pins
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         video_decode_select_out <= 1'b0;
         transport_select_out <= 1'b0;
         video_decode_select_oe <= 1'b0;
         transport_select_oe <= 1'b0;
      end
      else
      begin
         video_decode_select_out <= auto_reg ? detect_video : pins_q[3];
         transport_select_out <= auto_reg ? detect_ts : pins_q[4];
         video_decode_select_oe <= auto_reg;
         transport_select_oe <= auto_reg;
      end
   end

   // Both high is undefined; treated as data-through
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         fmt_reg <= vosm_pkg::VOSM_FMT_RAW;
      else if (video_decode_select_out & ~transport_select_out)
         fmt_reg <= vosm_pkg::VOSM_FMT_VIDEO;
      else if (~video_decode_select_out & transport_select_out)
         fmt_reg <= vosm_pkg::VOSM_FMT_TS;
      else
         fmt_reg <= vosm_pkg::VOSM_FMT_RAW;
   end

   // ----------------------------------------
   // Buffer bypass and aux initialisation
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         bypass_reg <= 1'b1;
         buffer_bypass <= 1'b1;
         buffer_sleep <= 1'b1;
      end
      else
      begin
         bypass_reg <= ~buf_en_s | ~proc_en_s | (buf_mode_reg == `VOSM_MODE_BYPASS);
         buffer_bypass <= bypass_reg;
         buffer_sleep <= bypass_reg;
      end
   end

   // Leaving aux mode or entering bypass restarts the wait, which lets an enable cycle clear it
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         init_reg <= vosm_pkg::VOSM_INIT_IDLE;
         init_cnt_reg <= 12'h000;
      end
      else if (bypass_reg || buf_mode_reg != `VOSM_MODE_AUX)
      begin
         init_reg <= vosm_pkg::VOSM_INIT_IDLE;
         init_cnt_reg <= 12'h000;
      end
      else
      begin
         unique case (init_reg)
            vosm_pkg::VOSM_INIT_IDLE:
               init_reg <= vosm_pkg::VOSM_INIT_RUN;
            vosm_pkg::VOSM_INIT_RUN:
               if (pclk_rise)
               begin
                  if (init_cnt_reg == 12'(INIT_CYCLES - 1))
                     init_reg <= vosm_pkg::VOSM_INIT_READY;
                  init_cnt_reg <= init_cnt_reg + 12'h001;
               end
            vosm_pkg::VOSM_INIT_READY:
               init_reg <= vosm_pkg::VOSM_INIT_READY;
            default:
               init_reg <= vosm_pkg::VOSM_INIT_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         aux_extract_enable <= 1'b0;
      else
         aux_extract_enable <= (init_reg == vosm_pkg::VOSM_INIT_READY) & proc_en_s;
   end

   // ----------------------------------------
   // Parallel data bus
   // ----------------------------------------
   wire logic force_low = auto_reg & ~trs_found & ~sync_found;

   // Data moves on the falling clock so it is stable at the output rise
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         dout <= '0;
         dout_oe <= 1'b0;
         pclk_out <= 1'b0;
         pclk_oe <= 1'b0;
      end
      else
      begin
         pclk_out <= pclk_s;
         pclk_oe <= 1'b1;
         dout_oe <= 1'b1;
         if (pclk_fall)
         begin
            if (force_low)
               dout <= '0;
            else
            begin
               unique case (fmt_reg)
                  vosm_pkg::VOSM_FMT_VIDEO:
                     dout <= video_word;
                  vosm_pkg::VOSM_FMT_TS:
                     dout <= {code_word_error, sync_word_indication, ts_byte};
                  default:
                     dout <= raw_word;
               endcase
            end
         end
      end
   end

   // ----------------------------------------
   // Status pins
   // ----------------------------------------
   // No reset here: pins keep their last level through reset
   always_ff @(posedge mclk)
   begin
      if (resetn)
         error_summary_n <= ~error_summary_in;
   end

   wire logic [7:0] stat_src = {buffer_empty, buffer_full, error_check_packet_flag, aux_packet_flag,
                                buffer_load_pulse, f_flag, v_flag, h_flag};

   genvar gi;
   generate
      for (gi = 0; gi < NSTAT; gi++)
      begin : g_stat
         logic [2:0] code;
         logic [2:0] dflt;
         logic relevant;
         assign code = sel_reg[gi*3 +: 3];
         always_comb
         begin
            dflt = `VOSM_SEL_H;
            if (fmt_reg == vosm_pkg::VOSM_FMT_VIDEO)
               dflt = 3'(gi);
            else if (fmt_reg == vosm_pkg::VOSM_FMT_TS && gi < 2)
               dflt = (gi == 0) ? `VOSM_SEL_FULL : `VOSM_SEL_EMPTY;
            relevant = (fmt_reg == vosm_pkg::VOSM_FMT_VIDEO) ? (code <= `VOSM_SEL_EDH) :
                       (fmt_reg == vosm_pkg::VOSM_FMT_TS) ? (code >= `VOSM_SEL_FULL) : 1'b0;
         end

         always_ff @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
            begin
               sel_reg[gi*3 +: 3] <= `VOSM_SEL_H;
               sel_written_reg[gi] <= 1'b0;
            end
            else if (wr_sel)
            begin
               sel_reg[gi*3 +: 3] <= hwdata[gi*`VOSM_SEL_FIELD_STRIDE +: 3];
               sel_written_reg[gi] <= 1'b1;
            end
            else if (cfg_change && !sel_written_reg[gi])
               sel_reg[gi*3 +: 3] <= dflt;
         end

         always_ff @(posedge mclk)
         begin
            if (resetn)
            begin
               stat_out[gi] <= stat_src[code];
               stat_oe[gi] <= relevant;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_bypass_enable: assert property (@(posedge mclk) disable iff (!resetn)
      !buf_en_s |-> ##2 buffer_bypass) else $error("bypass not taken");
   a_default_mode: assert property (@(posedge mclk) disable iff (!resetn)
      (fmt_reg == vosm_pkg::VOSM_FMT_RAW && fmt_prev_reg != vosm_pkg::VOSM_FMT_RAW && !wr_ctrl)
      |=> buf_mode_reg == `VOSM_MODE_BYPASS) else $error("mode default missed");
   a_ts_byte_map: assert property (@(posedge mclk) disable iff (!resetn)
      (pclk_fall && !force_low && fmt_reg == vosm_pkg::VOSM_FMT_TS)
      |=> dout == {$past(code_word_error), $past(sync_word_indication), $past(ts_byte)})
      else $error("transport map wrong");
   a_raw_pass: assert property (@(posedge mclk) disable iff (!resetn)
      (pclk_fall && !force_low && fmt_reg == vosm_pkg::VOSM_FMT_RAW) |=> dout == $past(raw_word))
      else $error("raw word altered");
   a_force_zero: assert property (@(posedge mclk) disable iff (!resetn)
      (pclk_fall && force_low) |=> dout == '0) else $error("bus not forced low");
   a_data_stable: assert property (@(posedge mclk) disable iff (!resetn)
      pclk_rise |=> $stable(dout)) else $error("data moved at clock rise");
   a_reset_float: assert property (@(posedge mclk)
      !resetn |-> !dout_oe && !pclk_oe && !video_decode_select_oe) else $error("drive in reset");
   a_stat_irrelevant: assert property (@(posedge mclk) disable iff (!resetn)
      (fmt_reg != vosm_pkg::VOSM_FMT_TS && sel_reg[2:0] >= `VOSM_SEL_FULL) |=> !stat_oe[0])
      else $error("full flag shown outside transport");
   a_init_wait: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(init_reg == vosm_pkg::VOSM_INIT_READY) |-> $past(init_cnt_reg) == 12'(INIT_CYCLES - 1))
      else $error("ready before init count");

   c_ts_mode: cover property (@(posedge mclk) disable iff (!resetn) fmt_reg == vosm_pkg::VOSM_FMT_TS && pclk_fall);
   c_aux_ready: cover property (@(posedge mclk) disable iff (!resetn) $rose(aux_extract_enable));
   c_forced: cover property (@(posedge mclk) disable iff (!resetn) pclk_fall && force_low);

endmodule

`default_nettype wire

// ### rtl/vosm_defines.svh
// Purpose: Offsets, fields, reset values and timing counts of the video output status mux
// Assumes: 32-bit AHB-Lite register words on aligned byte addresses
// Notes: Definitions only
`ifndef VOSM_DEFINES_SVH
`define VOSM_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VOSM_CTRL_OFS 8'h00
`define VOSM_SEL_OFS 8'h04
`define VOSM_STATUS_OFS 8'h08

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define VOSM_CTRL_MODE_LSB 0
`define VOSM_CTRL_AUTO_BIT 2
`define VOSM_CTRL_SWAP_BIT 12
`define VOSM_SEL_FIELD_STRIDE 4

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define VOSM_MODE_AUX 2'h2
`define VOSM_MODE_BYPASS 2'h3
`define VOSM_MODE_RESET 2'h3
`define VOSM_SEL_H 3'h0
`define VOSM_SEL_V 3'h1
`define VOSM_SEL_F 3'h2
`define VOSM_SEL_LOAD 3'h3
`define VOSM_SEL_EDH 3'h5
`define VOSM_SEL_FULL 3'h6
`define VOSM_SEL_EMPTY 3'h7

// ----------------------------------------
// Timing, in parallel clock cycles
// ----------------------------------------
`define VOSM_AUX_INIT_PCLK 2200

`endif

// ### rtl/vosm_pkg.sv
// Purpose: Types shared by the video output status mux
// Assumes: Nothing beyond the defines header
// Notes: Constants live in vosm_defines.svh
`default_nettype none
package vosm_pkg;

   // Output bus format chosen by the two select pins
   typedef enum logic [1:0]
   {
      VOSM_FMT_RAW = 2'h0,
      VOSM_FMT_VIDEO = 2'h1,
      VOSM_FMT_TS = 2'h2
   } vosm_fmt_type;

   // Aux buffer initialisation, Gray along idle-init-ready
   typedef enum logic [1:0]
   {
      VOSM_INIT_IDLE = 2'h0,
      VOSM_INIT_RUN = 2'h1,
      VOSM_INIT_READY = 2'h3
   } vosm_init_type;

endpackage

`default_nettype wire

// ### rtl/vosm_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module vosm_pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Pins
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q <= '0;
      end
      else
      begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_reg[i] == s3_reg[i])
            begin
               q[i] <= s3_reg[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

// ### tb/vosm_video_sink.sv
// Purpose: Downstream logic that captures the parallel bus
// Assumes: Words are taken at each driven rise of pclk_out
// Notes: Holds only the latest word and a running count
`timescale 1ns/10ps
`default_nettype none

module vosm_video_sink (
   // Parallel link from the block
   input wire logic pclk_out,
   input wire logic pclk_oe,
   input wire logic [9:0] dout,
   input wire logic dout_oe,
   // Captured words
   output logic [9:0] cap_word,
   output int cap_count
);
   initial cap_count = 0;

   // Capture on the output clock rise only while both are driven
   always @(posedge pclk_out)
   begin
      if (pclk_oe && dout_oe)
      begin
         cap_word <= dout;
         cap_count <= cap_count + 1;
      end
   end
endmodule

`default_nettype wire

// ### tb/test_video_output_status_mux.sv
// Purpose: Self-checking bench for the video output status mux
// Assumes: Zero-wait AHB-Lite slave, free-running pclk of 160 ns
// Notes: Small init count keeps the aux wait short
`timescale 1ns/10ps
`default_nettype none
`include "vosm_defines.svh"

module test_video_output_status_mux;
   localparam int INIT_N = 8;
   logic mclk, resetn, hsel, hwrite, pclk_in, buf_en, proc_en, vid_drv, ts_drv, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic vsel_out, vsel_oe, tsel_out, tsel_oe, vsel_pin, tsel_pin;
   logic [9:0] raw_word, video_word, dout, cap_word;
   logic [7:0] ts_byte, src;
   logic cwe, swi, trs, syn, det_v, det_t, err_in, dout_oe, pclk_out, pclk_oe, err_n, bypass, sleep, aux_en, swap;
   logic [3:0] stat_out, stat_oe, stat_keep;
   int fail_count, samples_checked, cap_count;

   // Wire level of the two-way select pins
   assign vsel_pin = vsel_oe ? vsel_out : vid_drv;
   assign tsel_pin = tsel_oe ? tsel_out : ts_drv;

   vosm_top #(.INIT_CYCLES(INIT_N)) u_dut (
      .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pclk_in(pclk_in), .buffer_enable_pin(buf_en), .processing_enable_pin(proc_en),
      .video_decode_select_in(vsel_pin), .video_decode_select_out(vsel_out), .video_decode_select_oe(vsel_oe),
      .transport_select_in(tsel_pin), .transport_select_out(tsel_out), .transport_select_oe(tsel_oe),
      .raw_word(raw_word), .video_word(video_word), .ts_byte(ts_byte), .code_word_error(cwe),
      .sync_word_indication(swi), .trs_found(trs), .sync_found(syn), .detect_video(det_v),
      .detect_ts(det_t), .error_summary_in(err_in), .h_flag(src[0]), .v_flag(src[1]), .f_flag(src[2]),
      .buffer_load_pulse(src[3]), .aux_packet_flag(src[4]), .error_check_packet_flag(src[5]),
      .buffer_full(src[6]), .buffer_empty(src[7]), .dout(dout), .dout_oe(dout_oe), .pclk_out(pclk_out),
      .pclk_oe(pclk_oe), .stat_out(stat_out), .stat_oe(stat_oe), .error_summary_n(err_n),
      .buffer_bypass(bypass), .buffer_sleep(sleep), .aux_extract_enable(aux_en), .half_swap_bit(swap)
   );

   vosm_video_sink u_sink (
      .pclk_out(pclk_out), .pclk_oe(pclk_oe), .dout(dout), .dout_oe(dout_oe),
      .cap_word(cap_word), .cap_count(cap_count)
   );

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Odd start offset keeps the link clock out of phase with mclk
   initial
   begin
      pclk_in = 1'b0;
      #7;
      forever #80 pclk_in = ~pclk_in;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic give_up();
      fail_count++;
      finish_test();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
            give_up();
         @(posedge mclk);
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, adr};
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      ahb(1'b0, adr, 32'h0);
      check(rd, exp);
      check({31'h0, hresp}, 32'h0);
   endtask

   task automatic set_fmt(input int f);
      vid_drv <= (f == 1);
      ts_drv <= (f == 2);
      wait_clk(40);
   endtask

   // Model of the output word for the current pins and core inputs
   task automatic word_check(input int f, input logic autom);
      int n;
      logic [9:0] exp;
      raw_word <= 10'($urandom);
      video_word <= 10'($urandom);
      ts_byte <= 8'($urandom);
      cwe <= 1'($urandom);
      swi <= 1'($urandom);
      err_in <= 1'($urandom);
      wait_clk(1);
      n = cap_count + 3;
      for (int k = 0; k < 200 && cap_count < n; k++)
         wait_clk(1);
      if (cap_count < n)
         give_up();
      exp = (autom && !trs && !syn) ? 10'h0 : (f == 1) ? video_word : (f == 2) ? {cwe, swi, ts_byte} : raw_word;
      check({22'h0, cap_word}, {22'h0, exp});
   endtask

   initial
   begin
      logic e;
      void'($urandom(89166));
      fail_count = 0;
      samples_checked = 0;
      {hsel, hwrite, haddr, hwdata, htrans, vid_drv, ts_drv, raw_word, video_word} = '0;
      // Late in the time step so every async reset branch sees the fall
      resetn <= 1'b0;
      {ts_byte, src, cwe, swi, det_v, det_t, err_in} = '0;
      {trs, syn, buf_en, proc_en} = 4'hf;
      hsize = 3'h2;
      wait_clk(16);
      resetn <= 1'b1;
      wait_clk(8);
      rd_chk(`VOSM_CTRL_OFS, 32'h3);
      rd_chk(`VOSM_SEL_OFS, 32'h0);
      rd_chk(8'h0c, 32'h0);
      rd_chk(`VOSM_STATUS_OFS, 32'h2);
      for (int f = 1; f < 4; f++)
      begin
         set_fmt(f % 3);
         rd_chk(`VOSM_SEL_OFS, (f == 1) ? 32'h3210 : (f == 2) ? 32'h76 : 32'h0);
         ahb(1'b0, `VOSM_STATUS_OFS, 32'h0);
         check({28'h0, rd[5:2]}, {28'h0, ts_drv, vid_drv, 2'(f % 3)});
         word_check(f % 3, 1'b0);
         word_check(f % 3, 1'b0);
      end
      for (int f = 0; f < 3; f++)
      begin
         set_fmt(f);
         for (int c = 0; c < 8; c++)
         begin
            src <= 8'($urandom);
            ahb(1'b1, `VOSM_SEL_OFS, {16'h0, {4{1'b0, 3'(c)}}});
            wait_clk(3);
            e = (f == 1) ? (c <= 5) : (f == 2) ? (c >= 6) : 1'b0;
            check({28'h0, stat_oe}, {28'h0, {4{e}}});
            if (e)
               check({28'h0, stat_out}, {28'h0, {4{src[c]}}});
         end
      end
      set_fmt(1);
      ahb(1'b1, `VOSM_CTRL_OFS, 32'h2);
      wait_clk(10);
      rd_chk(`VOSM_STATUS_OFS, 32'h14);
      buf_en <= 1'b0;
      wait_clk(10);
      check({30'h0, bypass, sleep}, 32'h3);
      buf_en <= 1'b1;
      proc_en <= 1'b0;
      wait_clk(10);
      check({31'h0, bypass}, 32'h1);
      proc_en <= 1'b1;
      wait_clk(10);
      check({30'h0, bypass, aux_en}, 32'h0);
      repeat (INIT_N + 4) @(posedge pclk_in);
      wait_clk(8);
      check({31'h0, aux_en}, 32'h1);
      rd_chk(`VOSM_STATUS_OFS, 32'h15);
      // Host clears the aux buffer by two full swap pulses, spaced apart
      for (int k = 1; k < 5; k++)
      begin
         ahb(1'b1, `VOSM_CTRL_OFS, {19'h0, 1'(k), 12'h2});
         wait_clk(1);
         check({31'h0, swap}, {31'h0, 1'(k)});
         repeat (1100) @(posedge pclk_in);
         wait_clk(1);
      end
      ahb(1'b1, `VOSM_CTRL_OFS, 32'h3);
      wait_clk(10);
      check({31'h0, bypass}, 32'h1);
      ahb(1'b1, `VOSM_CTRL_OFS, 32'h2);
      set_fmt(0);
      rd_chk(`VOSM_CTRL_OFS, 32'h3);
      ahb(1'b1, `VOSM_CTRL_OFS, 32'h7);
      det_t <= 1'b1;
      {trs, syn} <= 2'h0;
      wait_clk(40);
      check({28'h0, vsel_oe, tsel_oe, vsel_out, tsel_out}, 32'hd);
      word_check(2, 1'b1);
      syn <= 1'b1;
      wait_clk(4);
      word_check(2, 1'b1);
      stat_keep = stat_out;
      e = err_n;
      check({31'h0, err_n}, {31'h0, ~err_in});
      resetn <= 1'b0;
      wait_clk(2);
      check({28'h0, dout_oe, pclk_oe, vsel_oe, tsel_oe}, 32'h0);
      check({27'h0, e, stat_keep}, {27'h0, err_n, stat_out});
      resetn <= 1'b1;
      wait_clk(4);
      check({30'h0, dout_oe, pclk_oe}, 32'h3);
      finish_test();
   end

   initial
   begin
      #1900000;
      give_up();
   end
endmodule

`default_nettype wire
